// ==== rtl/swo_pkg.sv ====
// Shared constants and types for the switching-output command handler.
package swo_pkg;
    // Command line buffer and reply sizes, in characters.
    localparam int unsigned LINE_MAX = 12;
    localparam logic [3:0] LINE_MAX_CNT = 4'hc;
    localparam logic [3:0] LEN_SHORT = 4'h3;
    localparam logic [3:0] LEN_SET_NONE = 4'h2;
    localparam logic [3:0] LEN_SET_ONE = 4'h7;
    localparam logic [3:0] LEN_SET_TWO = 4'hc;
    localparam logic [3:0] LEN_REPLY_FIELDS = 4'hc;
    localparam logic [3:0] LEN_REPLY_STATUS = 4'h5;

    // Character codes.
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_1 = 8'h31;
    localparam logic [7:0] CH_2 = 8'h32;
    localparam logic [7:0] CH_3 = 8'h33;
    localparam logic [7:0] CH_SEMI = 8'h3b;
    localparam logic [7:0] CH_EQ = 8'h3d;
    localparam logic [7:0] CH_Q = 8'h3f;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_D = 8'h44;
    localparam logic [7:0] CH_F = 8'h46;
    localparam logic [7:0] CH_I = 8'h49;
    localparam logic [7:0] CH_O = 8'h4f;
    localparam logic [7:0] CH_P = 8'h50;
    localparam logic [7:0] CH_S = 8'h53;

    // Second digit of the set-states status answer.
    localparam logic [7:0] STS_OK = CH_0;
    localparam logic [7:0] STS_SYNTAX = CH_1;
    localparam logic [7:0] STS_PARAM = CH_2;
    localparam logic [7:0] STS_OTHER = CH_3;

    typedef enum logic [1:0] {
        FN_PASSIVE = 2'h0,
        FN_INPUT = 2'h1,
        FN_OUTPUT = 2'h2
    } swo_func_type;

    typedef enum logic [1:0] {
        FLD_OK = 2'h0,
        FLD_SYNTAX = 2'h1,
        FLD_PARAM = 2'h2
    } swo_fld_type;

    // Register map.
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam int unsigned CFG_FN1_LSB = 0;
    localparam int unsigned CFG_FN2_LSB = 2;
    localparam int unsigned CFG_INV_LSB = 4;
    localparam int unsigned STAT_LOGIC_LSB = 0;
    localparam int unsigned STAT_PIN_LSB = 2;
    localparam int unsigned STAT_OE_LSB = 4;
    localparam int unsigned STAT_BUSY_BIT = 6;
    localparam logic [1:0] INV_RST = 2'h0;
    localparam logic [1:0] LOGIC_RST = 2'h0;
endpackage

// ==== rtl/swo_reply_if.sv ====
// Reply hand-off between the command decoder and the reply sender.
`timescale 1ns/1ps
interface swo_reply_if;
    logic start;
    logic [3:0] len;
    logic [swo_pkg::LINE_MAX-1:0][7:0] text;
    logic busy;

    modport src (output start, output len, output text, input busy);
    modport snk (input start, input len, input text, output busy);
endinterface

// ==== rtl/swo_port_drv.sv ====
// One switching port: applies inversion and enables the driver in output mode.
`timescale 1ns/1ps
module swo_port_drv (
    input wire logic clk,                       // System clock.
    input wire logic sys_rst,                   // Synchronous reset.
    input wire swo_pkg::swo_func_type func,     // Configured port function.
    input wire logic invert,                    // Inversion enable.
    input wire logic logic_state,               // Commanded logic state.
    output logic pin_out,                       // Pin level.
    output logic pin_oe                         // Pin driver enable.
);
    typedef struct packed {
        logic pin;
        logic oe;
    } swo_drv_type;

    swo_drv_type q;
    swo_drv_type d;

    always_comb begin
        d = q;
        d.pin = logic_state ^ invert; // R3
        d.oe = (func == swo_pkg::FN_OUTPUT);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pin_out = q.pin;
    assign pin_oe = q.oe;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    pin_invert_a: assert property (##1 invert && logic_state |=> !pin_out) // R3
        else $error("Inverted high state did not drive the pin low.");
endmodule

// ==== rtl/swo_reply_tx.sv ====
// Sends a latched reply text character by character, closed by a carriage return.
`timescale 1ns/1ps
module swo_reply_tx (
    input wire logic clk,           // System clock.
    input wire logic sys_rst,       // Synchronous reset.
    swo_reply_if.snk rep,           // Reply from the decoder.
    output logic tx_valid,          // Reply byte valid.
    input wire logic tx_ready,      // Host takes the byte.
    output logic [7:0] tx_data      // Reply byte.
);
    typedef enum logic [0:0] {
        TX_IDLE = 1'h0,
        TX_SEND = 1'h1
    } swo_tx_st_type;

    typedef struct packed {
        swo_tx_st_type st;
        logic [3:0] idx;
        logic [3:0] len;
        logic [swo_pkg::LINE_MAX-1:0][7:0] text;
        logic [7:0] data;
    } swo_tx_type;

    swo_tx_type q;
    swo_tx_type d;

    always_comb begin
        d = q;
        case (q.st)
            TX_IDLE: begin
                // A reply offered while a previous one is still going out is dropped.
                if (rep.start) begin
                    d.st = TX_SEND;
                    d.text = rep.text;
                    d.len = rep.len;
                    d.idx = '0;
                    d.data = rep.text[0];
                end
            end
            TX_SEND: begin
                if (tx_ready) begin
                    if (q.idx == q.len) begin
                        d.st = TX_IDLE;
                    end else begin
                        d.idx = 4'(q.idx + 4'h1);
                        if (d.idx == q.len || d.idx >= swo_pkg::LINE_MAX_CNT) begin
                            d.data = swo_pkg::CH_CR;
                            d.idx = q.len;
                        end else begin
                            d.data = q.text[d.idx];
                        end
                    end
                end
            end
            default: d.st = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tx_valid = (q.st == TX_SEND);
    assign tx_data = q.data;
    assign rep.busy = (q.st != TX_IDLE);

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("Reply byte changed before the host took it.");
    tx_start_a: assert property (!rep.busy && rep.start |=> tx_valid && tx_data == swo_pkg::CH_O)
        else $error("Reply did not begin with its first character.");
endmodule

// ==== rtl/swo_cmd_top.sv ====
// Command decoder for the two switching ports, with register port and reply path.
// How it works
// R1 - Activate command with selector 1 or 2 sets that output's logic state high.
// R2 - Host only switches ports configured as outputs; others are left alone.
// R3 - Pin level is logic state exclusive-or the port's inversion bit.
// R4 - Deactivate command with selector 1 or 2 clears that output's logic state.
// R5 - State query answers one field per port: 0, 1, I or P.
// R6 - Reported output states are those last set by commands.
// R7 - Set-states command drives each named output port to 0 or 1.
// R8 - Set-states values for ports not configured as outputs are ignored.
// R9 - Set-states accepts any subset of fields in ascending port order.
// R10 - Set-states answers status 00 ok, 01 syntax, 02 parameter, 03 other.
// R11 - Configuration query answers port one's then port two's function.
// R12 - Function field is one character: I input, O output, P passive.
// R13 - Activate and deactivate commands send no answer at all.
`timescale 1ns/1ps
module swo_cmd_top (
    input wire logic clk,               // System clock, 100 MHz.
    input wire logic sys_rst,           // Synchronous reset, active high.
    input wire logic rx_valid,          // Command byte strobe.
    input wire logic [7:0] rx_data,     // Command byte.
    output logic tx_valid,              // Reply byte valid.
    input wire logic tx_ready,          // Host takes the reply byte.
    output logic [7:0] tx_data,         // Reply byte.
    input wire logic [7:0] reg_addr,    // Register address.
    input wire logic [31:0] reg_wdata,  // Register write data.
    input wire logic reg_wr,            // Register write strobe.
    input wire logic reg_rd,            // Register read strobe.
    output logic [31:0] reg_rdata,      // Read data, cycle after the strobe.
    output logic [1:0] sw_pin_out,      // Switching port levels.
    output logic [1:0] sw_pin_oe        // Switching port driver enables.
);
    typedef enum logic [0:0] {
        ST_RECV = 1'h0,
        ST_EXEC = 1'h1
    } swo_st_type;

    typedef struct packed {
        swo_st_type st;
        logic [3:0] len;
        logic ovf;
        logic [swo_pkg::LINE_MAX-1:0][7:0] line;
        logic [1:0] lstate;
        swo_pkg::swo_func_type [1:0] fn;
        logic [1:0] inv;
        logic [31:0] rdata;
    } swo_top_type;

    swo_top_type q;
    swo_top_type d;
    swo_reply_if rep ();

    function automatic swo_pkg::swo_fld_type fld_chk(input logic [7:0] s, input logic [7:0] n,
                                                     input logic [7:0] e, input logic [7:0] v);
        if (s != swo_pkg::CH_S || e != swo_pkg::CH_EQ) begin
            fld_chk = swo_pkg::FLD_SYNTAX;
        end else if ((n != swo_pkg::CH_1 && n != swo_pkg::CH_2) ||
                     (v != swo_pkg::CH_0 && v != swo_pkg::CH_1)) begin
            fld_chk = swo_pkg::FLD_PARAM;
        end else begin
            fld_chk = swo_pkg::FLD_OK;
        end
    endfunction

    function automatic logic [swo_pkg::LINE_MAX-1:0][7:0] pair_text(input logic [7:0] h,
                                                                   input logic [7:0] a,
                                                                   input logic [7:0] b);
        pair_text = {b, swo_pkg::CH_EQ, swo_pkg::CH_2, swo_pkg::CH_S, swo_pkg::CH_SEMI, a,
                     swo_pkg::CH_EQ, swo_pkg::CH_1, swo_pkg::CH_S, swo_pkg::CH_SP, h,
                     swo_pkg::CH_O};
    endfunction

    function automatic logic [7:0] fn_char(input swo_pkg::swo_func_type f);
        case (f)
            swo_pkg::FN_INPUT: fn_char = swo_pkg::CH_I;
            swo_pkg::FN_OUTPUT: fn_char = swo_pkg::CH_O;
            default: fn_char = swo_pkg::CH_P;
        endcase
    endfunction

    function automatic logic [7:0] state_char(input swo_pkg::swo_func_type f, input logic s);
        if (f == swo_pkg::FN_OUTPUT) begin
            state_char = s ? swo_pkg::CH_1 : swo_pkg::CH_0;
        end else if (f == swo_pkg::FN_INPUT) begin
            state_char = swo_pkg::CH_I;
        end else begin
            state_char = swo_pkg::CH_P;
        end
    endfunction

    // Command decode of the completed line.
    logic exec;
    logic is_oa;
    logic is_od;
    logic is_of;
    logic short_cmd;
    logic sel_ok;
    logic sel_port;
    logic exec_act;
    logic exec_deact;
    logic exec_oaq;
    logic exec_ofq;
    logic exec_set;
    swo_pkg::swo_fld_type fa;
    swo_pkg::swo_fld_type fb;
    logic [7:0] set_code;
    logic set_ok;
    logic has1;
    logic has2;
    logic val1;
    logic val2;

    assign exec = (q.st == ST_EXEC);
    assign is_oa = q.line[0] == swo_pkg::CH_O && q.line[1] == swo_pkg::CH_A;
    assign is_od = q.line[0] == swo_pkg::CH_O && q.line[1] == swo_pkg::CH_D;
    assign is_of = q.line[0] == swo_pkg::CH_O && q.line[1] == swo_pkg::CH_F;
    assign short_cmd = !q.ovf && q.len == swo_pkg::LEN_SHORT;
    assign sel_ok = q.line[2] == swo_pkg::CH_1 || q.line[2] == swo_pkg::CH_2; // R1
    assign sel_port = q.line[2] == swo_pkg::CH_2;
    assign exec_act = exec && is_oa && short_cmd && sel_ok;
    assign exec_deact = exec && is_od && short_cmd && sel_ok;
    assign exec_oaq = exec && is_oa && short_cmd && q.line[2] == swo_pkg::CH_Q;
    assign exec_ofq = exec && is_of && short_cmd && q.line[2] == swo_pkg::CH_Q;
    assign exec_set = exec && is_oa && !exec_act && !exec_oaq; // R13

    assign fa = fld_chk(q.line[3], q.line[4], q.line[5], q.line[6]);
    assign fb = fld_chk(q.line[8], q.line[9], q.line[10], q.line[11]);

    // A set-states line too long for the buffer is answered as an other error.
    always_comb begin
        if (q.ovf) begin
            set_code = swo_pkg::STS_OTHER; // R10
        end else if (q.len == swo_pkg::LEN_SET_NONE) begin
            set_code = swo_pkg::STS_OK; // R9
        end else if (q.line[2] != swo_pkg::CH_SP) begin
            set_code = swo_pkg::STS_SYNTAX;
        end else if (q.len == swo_pkg::LEN_SET_ONE) begin
            set_code = (fa == swo_pkg::FLD_OK) ? swo_pkg::STS_OK :
                       (fa == swo_pkg::FLD_PARAM) ? swo_pkg::STS_PARAM : swo_pkg::STS_SYNTAX;
        end else if (q.len == swo_pkg::LEN_SET_TWO) begin
            if (fa == swo_pkg::FLD_SYNTAX || fb == swo_pkg::FLD_SYNTAX ||
                q.line[7] != swo_pkg::CH_SEMI) begin
                set_code = swo_pkg::STS_SYNTAX;
            end else if (fa != swo_pkg::FLD_OK || fb != swo_pkg::FLD_OK ||
                         q.line[4] != swo_pkg::CH_1 || q.line[9] != swo_pkg::CH_2) begin
                set_code = swo_pkg::STS_PARAM; // R9
            end else begin
                set_code = swo_pkg::STS_OK;
            end
        end else begin
            set_code = swo_pkg::STS_SYNTAX;
        end
    end

    // Fields are applied only when the whole command is valid.
    assign set_ok = exec_set && set_code == swo_pkg::STS_OK;
    assign has1 = q.len == swo_pkg::LEN_SET_TWO ||
                  (q.len == swo_pkg::LEN_SET_ONE && q.line[4] == swo_pkg::CH_1);
    assign has2 = q.len == swo_pkg::LEN_SET_TWO ||
                  (q.len == swo_pkg::LEN_SET_ONE && q.line[4] == swo_pkg::CH_2);
    assign val1 = q.line[6] == swo_pkg::CH_1;
    assign val2 = (q.len == swo_pkg::LEN_SET_TWO) ? q.line[11] == swo_pkg::CH_1 : val1;

    always_comb begin
        d = q;
        rep.start = 1'b0;
        rep.len = '0;
        rep.text = '0;
        d.rdata = '0;
        case (q.st)
            ST_RECV: begin
                if (rx_valid) begin
                    if (rx_data == swo_pkg::CH_CR) begin
                        d.st = ST_EXEC;
                    end else if (q.len == swo_pkg::LINE_MAX_CNT) begin
                        d.ovf = 1'b1;
                    end else begin
                        d.line[q.len] = rx_data;
                        d.len = 4'(q.len + 4'h1);
                    end
                end
            end
            ST_EXEC: begin
                // Only ports set up as outputs take commanded states.
                if ((exec_act || exec_deact) && q.fn[sel_port] == swo_pkg::FN_OUTPUT) begin // R2
                    d.lstate[sel_port] = exec_act; // R1 R4 R6
                end
                if (set_ok && has1 && q.fn[0] == swo_pkg::FN_OUTPUT) begin // R8
                    d.lstate[0] = val1; // R7
                end
                if (set_ok && has2 && q.fn[1] == swo_pkg::FN_OUTPUT) begin // R8
                    d.lstate[1] = val2; // R7
                end
                if (exec_oaq) begin
                    rep.start = 1'b1;
                    rep.len = swo_pkg::LEN_REPLY_FIELDS;
                    rep.text = pair_text(swo_pkg::CH_A, state_char(q.fn[0], q.lstate[0]),
                                         state_char(q.fn[1], q.lstate[1])); // R5 R6
                end else if (exec_ofq) begin
                    rep.start = 1'b1;
                    rep.len = swo_pkg::LEN_REPLY_FIELDS;
                    rep.text = pair_text(swo_pkg::CH_F, fn_char(q.fn[0]),
                                         fn_char(q.fn[1])); // R11 R12
                end else if (exec_set) begin
                    rep.start = 1'b1;
                    rep.len = swo_pkg::LEN_REPLY_STATUS;
                    rep.text[0] = swo_pkg::CH_O;
                    rep.text[1] = swo_pkg::CH_A;
                    rep.text[2] = swo_pkg::CH_EQ;
                    rep.text[3] = swo_pkg::CH_0;
                    rep.text[4] = set_code; // R10
                end
                d.st = ST_RECV;
                d.len = '0;
                d.ovf = 1'b0;
                d.line = '0;
            end
            default: d.st = ST_RECV;
        endcase
        if (reg_wr && reg_addr == swo_pkg::REG_CFG) begin
            d.fn[0] = swo_pkg::swo_func_type'(reg_wdata[swo_pkg::CFG_FN1_LSB +: 2]);
            d.fn[1] = swo_pkg::swo_func_type'(reg_wdata[swo_pkg::CFG_FN2_LSB +: 2]);
            d.inv = reg_wdata[swo_pkg::CFG_INV_LSB +: 2];
        end
        if (reg_rd && reg_addr == swo_pkg::REG_CFG) begin
            d.rdata[swo_pkg::CFG_FN1_LSB +: 2] = q.fn[0];
            d.rdata[swo_pkg::CFG_FN2_LSB +: 2] = q.fn[1];
            d.rdata[swo_pkg::CFG_INV_LSB +: 2] = q.inv;
        end else if (reg_rd && reg_addr == swo_pkg::REG_STAT) begin
            d.rdata[swo_pkg::STAT_LOGIC_LSB +: 2] = q.lstate;
            d.rdata[swo_pkg::STAT_PIN_LSB +: 2] = sw_pin_out;
            d.rdata[swo_pkg::STAT_OE_LSB +: 2] = sw_pin_oe;
            d.rdata[swo_pkg::STAT_BUSY_BIT] = rep.busy;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
            q.fn <= '{swo_pkg::FN_PASSIVE, swo_pkg::FN_PASSIVE};
            q.inv <= swo_pkg::INV_RST;
            q.lstate <= swo_pkg::LOGIC_RST;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;

    for (genvar i = 0; i < 2; i++) begin : g_port
        swo_port_drv u_drv (
            .clk(clk),
            .sys_rst(sys_rst),
            .func(q.fn[i]),
            .invert(q.inv[i]),
            .logic_state(q.lstate[i]),
            .pin_out(sw_pin_out[i]),
            .pin_oe(sw_pin_oe[i])
        );
    end

    swo_reply_tx u_tx (
        .clk(clk),
        .sys_rst(sys_rst),
        .rep(rep),
        .tx_valid(tx_valid),
        .tx_ready(tx_ready),
        .tx_data(tx_data)
    );

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // A register write in the cycle after the command may change the inversion, so it is excluded.
    act_sets_a: assert property (exec_act && q.fn[sel_port] == swo_pkg::FN_OUTPUT // R1
        ##1 !reg_wr |-> q.lstate[$past(sel_port)]
        ##1 sw_pin_out[$past(sel_port, 2)] != q.inv[$past(sel_port, 2)])
        else $error("Activate did not raise the selected output.");
    deact_clears_a: assert property (exec_deact && q.fn[sel_port] == swo_pkg::FN_OUTPUT // R4
        |=> !q.lstate[$past(sel_port)])
        else $error("Deactivate did not clear the selected output.");
    quiet_switch_a: assert property (exec_act || exec_deact |-> !rep.start) // R13
        else $error("Activate or deactivate produced a reply.");
    state_reply_a: assert property (exec_oaq |-> rep.start // R5
        && rep.len == swo_pkg::LEN_REPLY_FIELDS
        && rep.text[6] == state_char(q.fn[0], q.lstate[0]))
        else $error("State query reply is wrong.");
    cfg_reply_a: assert property (exec_ofq |-> rep.text[1] == swo_pkg::CH_F // R12
        && rep.text[11] == fn_char(q.fn[1]))
        else $error("Configuration reply is wrong.");
    set_status_a: assert property (exec_set |-> rep.start // R10
        && rep.len == swo_pkg::LEN_REPLY_STATUS
        && rep.text[2] == swo_pkg::CH_EQ && rep.text[3] == swo_pkg::CH_0)
        else $error("Set-states reply is malformed.");
    set_drive_a: assert property (set_ok && has1 && q.fn[0] == swo_pkg::FN_OUTPUT // R7
        |=> q.lstate[0] == $past(val1))
        else $error("Set-states did not drive port one.");
    set_ignore_a: assert property (exec_set && q.fn[1] != swo_pkg::FN_OUTPUT // R8
        |=> q.lstate[1] == $past(q.lstate[1]))
        else $error("Set-states changed a port that is not an output.");
    rdata_once_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("Read data outside the read answer cycle.");

    act_cov_c: cover property (exec_act && q.fn[sel_port] == swo_pkg::FN_OUTPUT);
    set_two_c: cover property (set_ok && q.len == swo_pkg::LEN_SET_TWO);
    query_c: cover property (exec_oaq ##[1:40] tx_valid && tx_data == swo_pkg::CH_CR);
    ovf_c: cover property (exec_set && q.ovf);
endmodule

// ==== dv/swo_host_model.sv ====
// Host model: sends command lines byte by byte and gathers each reply line.
`timescale 1ns/1ps
module swo_host_model (
    input wire logic clk,           // System clock.
    output logic rx_valid,          // Command byte strobe.
    output logic [7:0] rx_data,     // Command byte.
    input wire logic tx_valid,      // Reply byte valid.
    output logic tx_ready,          // Reply byte taken.
    input wire logic [7:0] tx_data  // Reply byte.
);
    string reply = "";
    int lines = 0;
    logic slow = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b1;
    end
    // A slow host takes a reply byte only every other cycle.
    always @(posedge clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            if (tx_data === swo_pkg::CH_CR) lines++;
            else reply = {reply, string'(tx_data)};
        end
    end
    // The idle data line shows the inverse of the last byte, never a stale copy.
    task automatic send_line(input string s);
        for (int i = 0; i <= s.len(); i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= (i == s.len()) ? swo_pkg::CH_CR : s[i];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        @(posedge clk);
    endtask
endmodule

// ==== dv/swo_cmd_top_tb.sv ====
// Self-checking bench for the switching-output command handler.
`timescale 1ns/1ps
module swo_cmd_top_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic rx_valid, tx_valid, tx_ready;
    logic [7:0] rx_data, tx_data;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, rd;
    logic [1:0] sw_pin_out, sw_pin_oe;
    int fails = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    swo_cmd_top dut (.clk(clk), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sw_pin_out(sw_pin_out), .sw_pin_oe(sw_pin_oe));
    swo_host_model host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check_str(input string got, input string exp);
        samples_checked++;
        if (got != exp) begin
            fails++;
            $display("mismatch at %0t: reply '%s' expected '%s'", $time, got, exp);
        end
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // An empty expectation means no reply byte may appear within the wait.
    task automatic cmd(input string s, input string exp);
        int n;
        host.reply = "";
        n = host.lines;
        host.send_line(s);
        for (int i = 0; i < 100 && host.lines == n; i++) @(posedge clk);
        check_str(host.reply, exp);
    endtask
    task automatic pins(input logic [3:0] exp);
        check_val({28'h0, sw_pin_oe, sw_pin_out}, {28'h0, exp});
    endtask
    task automatic t_reset();
        cmd("OA?", "OA S1=P;S2=P");
        cmd("OF?", "OF S1=P;S2=P");
        reg_read(8'h40, rd);
        check_val(rd, 32'h0);
        pins(4'h0);
    endtask
    task automatic t_single();
        reg_write(swo_pkg::REG_CFG, 32'h16);
        reg_read(swo_pkg::REG_CFG, rd);
        check_val(rd, 32'h16);
        cmd("OF?", "OF S1=O;S2=I");
        pins(4'h5);
        cmd("OA1", "");
        pins(4'h4);
        cmd("OA2", "");
        cmd("OA?", "OA S1=1;S2=I");
        reg_read(swo_pkg::REG_STAT, rd);
        check_val(rd, 32'h11);
        cmd("OD1", "");
        cmd("OA?", "OA S1=0;S2=I");
        pins(4'h5);
    endtask
    task automatic t_set();
        host.slow = 1'b1;
        reg_write(swo_pkg::REG_CFG, 32'h0a);
        cmd("OA S1=1;S2=1", "OA=00");
        pins(4'hf);
        cmd("OD2", "");
        pins(4'hd);
        cmd("OA2", "");
        pins(4'hf);
        cmd("OA S2=0", "OA=00");
        cmd("OA?", "OA S1=1;S2=0");
        cmd("OA S1+1", "OA=01");
        cmd("OA S1=5", "OA=02");
        cmd("OA S2=1;S1=0", "OA=02");
        cmd("OA S1=0;S2=1;", "OA=03");
        cmd("OA", "OA=00");
        cmd("OA?", "OA S1=1;S2=0");
        host.slow = 1'b0;
    endtask
    task automatic t_ignore();
        reg_write(swo_pkg::REG_CFG, 32'h02);
        cmd("OA S1=0;S2=1", "OA=00");
        cmd("OA?", "OA S1=0;S2=P");
        pins(4'h4);
        reg_write(swo_pkg::REG_STAT, 32'hff);
        reg_read(swo_pkg::REG_STAT, rd);
        check_val(rd, 32'h10);
        // Function code 3 reads back unchanged and is reported as passive.
        reg_write(swo_pkg::REG_CFG, 32'h3e);
        reg_read(swo_pkg::REG_CFG, rd);
        check_val(rd, 32'h3e);
        cmd("OF?", "OF S1=O;S2=P");
        cmd("OA?", "OA S1=0;S2=P");
        pins(4'h7);
    endtask
    initial begin
        #200000;
        fails++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_single();
        t_set();
        t_ignore();
        tally_and_finish();
    end
endmodule
